// ### smrc_pkg.sv
/*
 * types for the sleep mode and reset control block.
 * assumes smrc_regs.svh for register constants; mode and state codes are set here.
 */
package smrc_pkg;

    // sleep mode encodings as written by software
    typedef enum logic [2:0] {
        SMRC_SM_IDLE = 3'h0,
        SMRC_SM_ADCNR = 3'h1,
        SMRC_SM_PDOWN = 3'h2,
        SMRC_SM_PSAVE = 3'h3,
        SMRC_SM_STBY = 3'h6,
        SMRC_SM_XSTBY = 3'h7
    } smrc_mode_t;

    // sequencer states, gray along run -> sleep -> wake
    typedef enum logic [1:0] {
        SMRC_ST_RUN = 2'b00,
        SMRC_ST_SLEEP = 2'b01,
        SMRC_ST_WAKE = 2'b11
    } smrc_state_t;

    // clock and function gate enables
    typedef struct packed {
        logic cpu;
        logic io;
        logic osc;
        logic async_tmr;
        logic adc;
    } smrc_gates_t;

    // legacy compatibility controls to peripherals
    typedef struct packed {
        logic wdt_timed_seq_en;
        logic rx_double_buf_en;
    } smrc_compat_t;

endpackage : smrc_pkg

// ### smrc_regs.svh
/*
 * register offsets, field positions, reset values and timing counts for the
 * sleep mode and reset control block.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
`ifndef SMRC_REGS_SVH
`define SMRC_REGS_SVH

// byte offsets
`define SMRC_CTRL_OFF 12'h000
`define SMRC_STAT_OFF 12'h004
`define SMRC_PULL_OFF 12'h008
`define SMRC_DIR_OFF 12'h00C
`define SMRC_OUT_OFF 12'h010
`define SMRC_PIN_OFF 12'h014

// control fields
`define SMRC_CTRL_SE_BIT 0
`define SMRC_CTRL_SM_LSB 1
`define SMRC_CTRL_ADCEN_BIT 4
`define SMRC_CTRL_RST 32'h0000_0000

// status fields
`define SMRC_STAT_SLEEP_BIT 0
`define SMRC_STAT_MODE_LSB 1
`define SMRC_STAT_FUSE_BIT 4
`define SMRC_STAT_EXTRF_BIT 5

// port register reset value
`define SMRC_PORT_RST 32'h0000_0000

// minimum external reset pulse, ns, and derived cycle count (rounded up)
`define SMRC_RST_MIN_NS 1500
`define SMRC_CLK_NS 8
`define SMRC_RST_MIN_CYC ((`SMRC_RST_MIN_NS + `SMRC_CLK_NS - 1) / `SMRC_CLK_NS)

`endif

// ### smrc_tb.sv
/*
 * self-checking testbench for the sleep mode and reset control block.
 * assumes smrc_pkg and smrc_regs.svh are compiled first; apb slave answers at once.
 */
`timescale 1ns/1ps
`include "smrc_regs.svh"

module testbench
    import smrc_pkg::*;
;
    // apb and pins
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, port_out, port_oe, port_pullup, rq;
    logic pready, pslverr, sys_reset_n, osc_out, re;
    logic sleep_req = 0, wake_irq = 0, fuse = 0, ext_reset_n = 1, osc_in = 0;
    logic [31:0] port_in = 32'h1234_5678;
    logic [7:0] ana_en;
    smrc_gates_t gates;
    smrc_compat_t compat;
    int n_errors = 0, n_checks = 0;

    smrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .wake_irq(wake_irq), .legacy_compat_fuse(fuse),
        .ext_reset_n(ext_reset_n), .sys_reset_n(sys_reset_n), .oscillator_input_pin(osc_in),
        .oscillator_output_pin(osc_out), .gates(gates), .compat(compat), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe), .port_pullup(port_pullup),
        .analog_shared_port_pins_ana_en(ana_en));

    // 125 mhz clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    task stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            i++;
            if (i > 20) begin
                n_errors++;
                stop_test();
            end
            @(posedge pclk);
        end
        rq = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    // reset values of outputs and registers
    task t_reset;
        chk("oe", 0, port_oe);
        chk("gates", 5'h1f, gates);
        chk("compat", 2'b11, compat);
        apb(0, `SMRC_PULL_OFF, 0);
        chk("pull", `SMRC_PORT_RST, rq);
    endtask : t_reset

    // every sleep mode: gate pattern, status, wake restores
    task t_modes;
        smrc_mode_t m [6] = '{SMRC_SM_IDLE, SMRC_SM_ADCNR, SMRC_SM_PDOWN, SMRC_SM_PSAVE, SMRC_SM_STBY, SMRC_SM_XSTBY};
        logic [4:0] g [6] = '{5'b01111, 5'b00111, 5'b00000, 5'b00010, 5'b00100, 5'b00110};
        int i, k;
        apb(1, `SMRC_PULL_OFF, 32'h5A5A_0000);
        for (i = 0; i < 6; i++) begin
            apb(1, `SMRC_CTRL_OFF, (32'(m[i]) << `SMRC_CTRL_SM_LSB) | 32'h0000_0001);
            @(posedge pclk);
            sleep_req <= 1;
            osc_in <= i[0];
            @(posedge pclk);
            sleep_req <= 0;
            cyc(2);
            chk("gates", g[i], gates);
            chk("osc_out", g[i][2] && !i[0], osc_out);
            apb(0, `SMRC_STAT_OFF, 0);
            chk("stat", (32'(m[i]) << 1) | 32'h0000_0001, rq & 32'h0000_000F);
            wake_irq <= 1;
            k = 0;
            while (gates !== 5'h1f) begin
                k++;
                if (k > 20) begin
                    n_errors++;
                    stop_test();
                end
                cyc(1);
            end
            wake_irq <= 0;
            apb(0, `SMRC_PULL_OFF, 0);
            chk("kept", 32'h5A5A_0000, rq);
        end
        // reserved mode code must not be stored
        apb(1, `SMRC_CTRL_OFF, 32'h0000_0008);
        apb(0, `SMRC_CTRL_OFF, 0);
        chk("mode", 32'h0000_0007, (rq >> 1) & 32'h0000_0007);
    endtask : t_modes

    // ports, pull-ups, analog sharing, reset tri-state
    task t_ports;
        apb(1, `SMRC_DIR_OFF, 32'h0F0F_0F0F);
        apb(1, `SMRC_OUT_OFF, 32'hAAAA_AAAA);
        apb(1, `SMRC_PULL_OFF, 32'hFFFF_FFFF);
        cyc(1);
        chk("oe", 32'h0F0F_0F0F, port_oe);
        chk("out", 32'hAAAA_AAAA, port_out);
        chk("pullup", 32'hF0F0_F0F0, port_pullup);
        apb(1, `SMRC_CTRL_OFF, 32'h0000_0010);
        cyc(1);
        chk("ana", 8'hFF, ana_en);
        chk("oe0", 32'h0F0F_0F00, port_oe);
        chk("pu0", 32'hF0F0_F000, port_pullup);
        apb(0, `SMRC_PIN_OFF, 0);
        chk("pin", 32'h1234_5678, rq);
        apb(0, 12'h100, 0);
        chk("unmapped", 32'h0000_0001, {rq[30:0], re});
        // short pulse tri-states at once but leaves state alone
        @(posedge pclk);
        ext_reset_n <= 0;
        #1;
        chk("short_oe", 0, port_oe);
        chk("short_rst", 0, sys_reset_n);
        cyc(10);
        ext_reset_n <= 1;
        cyc(4);
        chk("after_short", 32'h0F0F_0F00, port_oe);
        // power-down first: a long pulse wakes it, latches a reset and flags it
        apb(1, `SMRC_CTRL_OFF, 32'h0000_0015);
        @(posedge pclk);
        sleep_req <= 1;
        @(posedge pclk);
        sleep_req <= 0;
        cyc(1);
        chk("pd_gates", 0, gates);
        ext_reset_n <= 0;
        cyc(200);
        chk("rst_wake", 5'h1f, gates);
        chk("long_rst", 0, sys_reset_n);
        ext_reset_n <= 1;
        cyc(1);
        chk("held_rst", 0, sys_reset_n);
        cyc(5);
        apb(0, `SMRC_STAT_OFF, 0);
        chk("ext_flag", 1, rq[`SMRC_STAT_EXTRF_BIT]);
        apb(1, `SMRC_STAT_OFF, 32'h0000_0020);
        apb(0, `SMRC_STAT_OFF, 0);
        chk("flag_clr", 0, rq[`SMRC_STAT_EXTRF_BIT]);
    endtask : t_ports

    // legacy fuse and a second system reset
    task t_fuse;
        @(posedge pclk);
        fuse <= 1;
        cyc(4);
        chk("wdt_seq", 0, compat.wdt_timed_seq_en);
        chk("rx_dbuf", 0, compat.rx_double_buf_en);
        apb(0, `SMRC_STAT_OFF, 0);
        chk("fuse", 1, rq[`SMRC_STAT_FUSE_BIT]);
        apb(1, `SMRC_DIR_OFF, 32'hFFFF_FFFF);
        @(posedge pclk);
        presetn <= 0;
        #1;
        chk("rst_oe", 0, port_oe);
        cyc(2);
        presetn <= 1;
        apb(0, `SMRC_DIR_OFF, 0);
        chk("dir", `SMRC_PORT_RST, rq);
    endtask : t_fuse

    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        cyc(1);
        t_reset();
        t_modes();
        t_ports();
        t_fuse();
        stop_test();
    end

endmodule : testbench

// ### smrc_top.sv
/*
 * sleep mode and reset control: sleep mode gating, external reset filter,
 * port tri-state in reset, pull-up selection, legacy compatibility outputs.
 * assumes an apb master on pclk, pins pass in from outside the clock domain,
 * and the cpu raises sleep_req when it executes its sleep instruction.
 */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "smrc_regs.svh"

// What this block does
// - six software selected power saving modes
// - idle halts cpu, peripherals keep running
// - power-down freezes oscillator until wake
// - power-save keeps asynchronous timer counting
// - adc noise mode keeps timer and adc
// - standby keeps main oscillator running
// - extended standby keeps oscillator and timer
// - legacy fuse disables watchdog timed sequence
// - legacy fuse disables receive double buffering
// - ports tri-state whenever reset is active
// - long external reset low resets, clockless
// - per-bit pull-up enable on each port
// - first port analog unless converter unused
module smrc_top
    import smrc_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu and wake sources
    input wire logic sleep_req,
    input wire logic wake_irq,
    input wire logic legacy_compat_fuse,
    // external reset pin
    input wire logic ext_reset_n,
    output logic sys_reset_n,
    // oscillator pins
    input wire logic oscillator_input_pin,
    output logic oscillator_output_pin,
    // gates and compatibility controls
    output smrc_gates_t gates,
    output smrc_compat_t compat,
    // four ports, 8 bits each; port 0 is analog_shared_port_pins
    input wire logic [31:0] port_in,
    output logic [31:0] port_out,
    output logic [31:0] port_oe,
    output logic [31:0] port_pullup,
    output logic [7:0] analog_shared_port_pins_ana_en
);

    localparam int unsigned RST_MIN = `SMRC_RST_MIN_CYC;

    smrc_state_t state_q;
    smrc_mode_t mode_q;
    logic sleep_en_q;
    logic adc_en_q;
    logic [31:0] pull_q;
    logic [31:0] dir_q;
    logic [31:0] out_q;
    logic [1:0] ext_sync_q;
    logic [1:0] wake_sync_q;
    logic [1:0] fuse_sync_q;
    logic [31:0] pin_s1_q;
    logic [31:0] pin_s2_q;
    logic [15:0] rst_cnt_q;
    logic ext_rst_q;
    logic extrf_q;
    logic wake_now;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_d;
    logic err_d;

    // decode mode to legal; unused codes are not stored and the previous mode is kept
    function automatic logic mode_legal(input logic [2:0] m);
        case (m)
            SMRC_SM_IDLE, SMRC_SM_ADCNR, SMRC_SM_PDOWN,
            SMRC_SM_PSAVE, SMRC_SM_STBY, SMRC_SM_XSTBY: mode_legal = 1'b1;
            default: mode_legal = 1'b0;
        endcase
    endfunction : mode_legal

    // gate enables for a mode while asleep
    function automatic smrc_gates_t sleep_gates(input smrc_mode_t m);
        smrc_gates_t g;
        g = '0;
        case (m)
            SMRC_SM_IDLE: g = '{cpu: 1'b0, io: 1'b1, osc: 1'b1, async_tmr: 1'b1, adc: 1'b1};
            SMRC_SM_ADCNR: g = '{cpu: 1'b0, io: 1'b0, osc: 1'b1, async_tmr: 1'b1, adc: 1'b1};
            SMRC_SM_PDOWN: g = '0;
            SMRC_SM_PSAVE: g = '{cpu: 1'b0, io: 1'b0, osc: 1'b0, async_tmr: 1'b1, adc: 1'b0};
            SMRC_SM_STBY: g = '{cpu: 1'b0, io: 1'b0, osc: 1'b1, async_tmr: 1'b0, adc: 1'b0};
            SMRC_SM_XSTBY: g = '{cpu: 1'b0, io: 1'b0, osc: 1'b1, async_tmr: 1'b1, adc: 1'b0};
            default: g = '1;
        endcase
        sleep_gates = g;
    endfunction : sleep_gates

    // synchronisers for pins and asynchronous sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_q <= 2'b11;
            wake_sync_q <= 2'b00;
            fuse_sync_q <= 2'b00;
            pin_s1_q <= 32'h0000_0000;
            pin_s2_q <= 32'h0000_0000;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_reset_n};
            wake_sync_q <= {wake_sync_q[0], wake_irq};
            fuse_sync_q <= {fuse_sync_q[0], legacy_compat_fuse};
            pin_s1_q <= port_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // external reset pulse filter: low for the minimum length latches reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q <= 16'h0000;
            ext_rst_q <= 1'b0;
        end else if (ext_sync_q[1]) begin
            rst_cnt_q <= 16'h0000;
            ext_rst_q <= 1'b0;
        end else if (rst_cnt_q < 16'(RST_MIN)) begin
            rst_cnt_q <= rst_cnt_q + 16'h0001;
        end else begin
            ext_rst_q <= 1'b1;
        end
    end

    // the pin also acts with no clock: a long low reaches reset directly
    assign sys_reset_n = presetn & ~ext_rst_q & ext_reset_n;

    // oscillator amplifier: inverted input while the oscillator runs
    assign oscillator_output_pin = gates.osc ? ~oscillator_input_pin : 1'b0;

    assign wake_now = wake_sync_q[1];

    // sleep sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SMRC_ST_RUN;
        end else begin
            case (state_q)
                SMRC_ST_RUN: begin
                    if (sleep_req && sleep_en_q && !wake_now) begin
                        state_q <= SMRC_ST_SLEEP;
                    end
                end
                SMRC_ST_SLEEP: begin
                    // an interrupt or a latched external reset ends any sleep
                    if (wake_now || ext_rst_q) begin
                        state_q <= SMRC_ST_WAKE;
                    end
                end
                SMRC_ST_WAKE: state_q <= SMRC_ST_RUN;
                default: state_q <= SMRC_ST_RUN;
            endcase
        end
    end

    // gate outputs; all clocks return on wake, nothing else is touched
    always_comb begin
        if (state_q == SMRC_ST_SLEEP) begin
            gates = sleep_gates(mode_q);
        end else begin
            gates = '1;
        end
    end

    // legacy compatibility controls
    assign compat.wdt_timed_seq_en = ~fuse_sync_q[1];
    assign compat.rx_double_buf_en = ~fuse_sync_q[1];

    // ports: released only when out of reset, as an async term
    always_comb begin
        port_oe = sys_reset_n ? dir_q : 32'h0000_0000;
        port_out = sys_reset_n ? out_q : 32'h0000_0000;
        port_pullup = sys_reset_n ? (pull_q & ~dir_q) : 32'h0000_0000;
        if (adc_en_q) begin
            port_oe[7:0] = 8'h00;
            port_pullup[7:0] = 8'h00;
        end
    end
    assign analog_shared_port_pins_ana_en = adc_en_q ? 8'hFF : 8'h00;

    // apb access
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_en_q <= 1'b0;
            mode_q <= SMRC_SM_IDLE;
            adc_en_q <= 1'b0;
            pull_q <= `SMRC_PORT_RST;
            dir_q <= `SMRC_PORT_RST;
            out_q <= `SMRC_PORT_RST;
        end else if (wr_en) begin
            if (paddr == `SMRC_CTRL_OFF) begin
                sleep_en_q <= pwdata[`SMRC_CTRL_SE_BIT];
                if (mode_legal(pwdata[`SMRC_CTRL_SM_LSB +: 3])) begin
                    mode_q <= smrc_mode_t'(pwdata[`SMRC_CTRL_SM_LSB +: 3]);
                end
                adc_en_q <= pwdata[`SMRC_CTRL_ADCEN_BIT];
            end else if (paddr == `SMRC_PULL_OFF) begin
                pull_q <= pwdata;
            end else if (paddr == `SMRC_DIR_OFF) begin
                dir_q <= pwdata;
            end else if (paddr == `SMRC_OUT_OFF) begin
                out_q <= pwdata;
            end
        end
    end

    // sticky external reset flag, cleared by writing one; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extrf_q <= 1'b0;
        end else if (ext_rst_q) begin
            extrf_q <= 1'b1;
        end else if (wr_en && paddr == `SMRC_STAT_OFF && pwdata[`SMRC_STAT_EXTRF_BIT]) begin
            extrf_q <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == `SMRC_CTRL_OFF) begin
            rd_d[`SMRC_CTRL_SE_BIT] = sleep_en_q;
            rd_d[`SMRC_CTRL_SM_LSB +: 3] = mode_q;
            rd_d[`SMRC_CTRL_ADCEN_BIT] = adc_en_q;
        end else if (paddr == `SMRC_STAT_OFF) begin
            rd_d[`SMRC_STAT_SLEEP_BIT] = (state_q == SMRC_ST_SLEEP);
            rd_d[`SMRC_STAT_MODE_LSB +: 3] = mode_q;
            rd_d[`SMRC_STAT_FUSE_BIT] = fuse_sync_q[1];
            rd_d[`SMRC_STAT_EXTRF_BIT] = extrf_q;
        end else if (paddr == `SMRC_PULL_OFF) begin
            rd_d = pull_q;
        end else if (paddr == `SMRC_DIR_OFF) begin
            rd_d = dir_q;
        end else if (paddr == `SMRC_OUT_OFF) begin
            rd_d = out_q;
        end else if (paddr == `SMRC_PIN_OFF) begin
            rd_d = pin_s2_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // read data registered in setup, stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_d;
        end
    end

    assign pslverr = psel & penable & err_d;

    // checks
    a_idle_cpu_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_IDLE) |-> (!gates.cpu && gates.io))
        else $error("idle gating wrong");
    a_pdown_all_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_PDOWN) |-> (gates == '0))
        else $error("power-down gating wrong");
    a_psave_tmr_on: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_PSAVE) |-> (gates.async_tmr && !gates.osc))
        else $error("power-save gating wrong");
    a_adcnr_gates: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_ADCNR) |-> (gates.adc && !gates.io))
        else $error("adc noise gating wrong");
    a_stby_osc_on: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_STBY) |-> (gates.osc && !gates.async_tmr))
        else $error("standby gating wrong");
    a_xstby_gates: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && mode_q == SMRC_SM_XSTBY) |-> (gates.osc && gates.async_tmr))
        else $error("extended standby gating wrong");
    a_fuse_compat: assert property (@(posedge pclk) disable iff (!presetn)
        fuse_sync_q[1] |-> (compat == 2'b00))
        else $error("legacy fuse not applied");
    a_wake_restore: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && wake_now) |=> (state_q == SMRC_ST_WAKE) ##1 (gates == '1))
        else $error("wake did not restore clocks");
    a_reset_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rst_q |-> (port_oe == 32'h0000_0000))
        else $error("ports driven in reset");

    // checks on compatibility, reset, ports and sequencing
    a_fuse_rx_single: assert property (@(posedge pclk) disable iff (!presetn)
        fuse_sync_q[1] |-> !compat.rx_double_buf_en)
        else $error("receive double buffering kept with fuse");
    a_nofuse_compat: assert property (@(posedge pclk) disable iff (!presetn)
        !fuse_sync_q[1] |-> (compat == 2'b11))
        else $error("compatibility controls active without fuse");
    a_reset_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !sys_reset_n |-> ((port_oe | port_out | port_pullup) == 32'h0000_0000))
        else $error("port outputs active in reset");
    a_long_rst_out: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rst_q |-> !sys_reset_n)
        else $error("latched reset not driven out");
    a_rst_cnt_bound: assert property (@(posedge pclk) disable iff (!presetn)
        rst_cnt_q <= 16'(RST_MIN))
        else $error("reset filter counter overran");
    a_extrf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ext_rst_q |=> extrf_q)
        else $error("external reset flag not set");
    a_pullup_input: assert property (@(posedge pclk) disable iff (!presetn)
        (port_pullup & port_oe) == 32'h0000_0000)
        else $error("pull-up on a driven pin");
    a_analog_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        adc_en_q |-> ((port_oe[7:0] | port_pullup[7:0]) == 8'h00 && analog_shared_port_pins_ana_en == 8'hFF))
        else $error("analog port still digital");
    a_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
        mode_legal(mode_q))
        else $error("illegal sleep mode stored");
    a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_RUN && sleep_req && sleep_en_q && !wake_now) |=> (state_q == SMRC_ST_SLEEP))
        else $error("sleep request not taken");
    a_reset_wakes: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_SLEEP && ext_rst_q) |=> (state_q == SMRC_ST_WAKE))
        else $error("external reset did not wake");
    a_osc_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        !gates.osc |-> !oscillator_output_pin)
        else $error("oscillator output runs while frozen");
    a_awake_all_on: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != SMRC_ST_SLEEP) |-> (gates == '1))
        else $error("clocks gated while awake");
    a_wake_to_run: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == SMRC_ST_WAKE) |=> (state_q == SMRC_ST_RUN))
        else $error("wake did not return to run");

endmodule : smrc_top
